// ===== hdl/csf_consts.vh
// Constants for the codec serial frame timing block
`ifndef CSF_CONSTS_VH
`define CSF_CONSTS_VH
`define CSF_WORD_BITS 16
`define CSF_CNT_W 5
`define CSF_CNT_ZERO 5'h00
`define CSF_CNT_ONE 5'h01
`define CSF_CNT_TX_LOAD 5'h0f
`define CSF_CNT_RX_LOAD 5'h10
`define CSF_MSB 15
`define CSF_WORD_ZERO 16'h0000
`define CSF_GAIN_SQUELCH 2'h0
`define CSF_GAIN_FULL3V 2'h1
`define CSF_GAIN_RESET 2'h0
`define CSF_SCLK_PERIOD_NS 125
`endif

// ===== hdl/csf_frame_timing.v
// Serial frame timing, shift engine, delayed frame sync and gain select of the codec
`timescale 1ns/1ps
`include "csf_consts.vh"

// Operation
// - Each output bit is launched on a rising edge of the shift clock.
// - Each input bit is sampled on a falling edge of the shift clock.
// - One sample exchange happens between successive falling edges of frame sync.
// - The delayed frame sync goes low exactly m shift clocks after each frame sync, m being the delay value.
// - Master and all slaves take one delay value so every hop has the same delay.
// - With a delay of zero the delayed frame sync falls straight from the frame sync fall.
// - With a delay of one or more the delayed frame sync edges are timed from rising shift clock edges.
// - The two gain bits pick squelch or a full-scale range, code 01 being half scale when single ended.
module csf_frame_timing #(
  parameter DELAY_W = 8
) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Link pins
  input wire shiftClk,
  input wire frame_sync_n,
  input wire serialIn,
  output reg serialOut,
  output reg serialOutEnN,
  output reg delayed_frame_sync_n,
  // Configuration
  input wire [DELAY_W-1:0] fsdDelay,
  input wire singleEnded,
  input wire input_gain_sel_hi,
  input wire input_gain_sel_lo,
  // User side
  input wire [`CSF_WORD_BITS-1:0] txWord,
  output reg [`CSF_WORD_BITS-1:0] rxWord,
  output reg rxValid,
  output reg frameStart,
  output reg squelch,
  output reg halfScale,
  output reg [1:0] gainRange
);

  function isRise;
    input cur;
    input prev;
    begin
      isRise = cur & ~prev;
    end
  endfunction

  function isFall;
    input cur;
    input prev;
    begin
      isFall = ~cur & prev;
    end
  endfunction

  // Count-down step shared by both word counters
  function [`CSF_CNT_W-1:0] cntDec;
    input [`CSF_CNT_W-1:0] cnt;
    begin
      cntDec = cnt - `CSF_CNT_ONE;
    end
  endfunction

  // Pin synchronisers; only the second stage and the history stage are read
  // Reset to the pins' idle levels so no false edge follows reset
  reg sclkMeta_q, sclkSync_q, sclkPrev_q;
  reg fsMeta_q, fsSync_q, fsPrev_q;
  reg dinMeta_q, dinSync_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      sclkMeta_q <= 1'b0;
      sclkSync_q <= 1'b0;
      sclkPrev_q <= 1'b0;
      fsMeta_q <= 1'b1;
      fsSync_q <= 1'b1;
      fsPrev_q <= 1'b1;
      dinMeta_q <= 1'b0;
      dinSync_q <= 1'b0;
    end else begin
      sclkMeta_q <= shiftClk;
      sclkSync_q <= sclkMeta_q;
      sclkPrev_q <= sclkSync_q;
      fsMeta_q <= frame_sync_n;
      fsSync_q <= fsMeta_q;
      fsPrev_q <= fsSync_q;
      dinMeta_q <= serialIn;
      dinSync_q <= dinMeta_q;
    end
  end

  // Frame sync and clock are both external; nothing here drives them
  wire sclkRise = isRise(sclkSync_q, sclkPrev_q);
  wire sclkFall = isFall(sclkSync_q, sclkPrev_q);
  wire fsFall = isFall(fsSync_q, fsPrev_q);
  // Equal path latency keeps an FS fall aligned with its clock rise
  // only while the far side holds the quarter-period window
  wire fsAtRise = fsFall;

  // Transmit shifter
  reg [`CSF_WORD_BITS-1:0] txShift_q;
  reg [`CSF_CNT_W-1:0] txCnt_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      txShift_q <= `CSF_WORD_ZERO;
      txCnt_q <= `CSF_CNT_ZERO;
      serialOut <= 1'b0;
      serialOutEnN <= 1'b1;
    end else if (fsAtRise) begin
      // MSB goes out at the rise that frames the word
      txShift_q <= {txWord[`CSF_MSB-1:0], 1'b0};
      serialOut <= txWord[`CSF_MSB];
      serialOutEnN <= 1'b0;
      txCnt_q <= `CSF_CNT_TX_LOAD;
    end else if (sclkRise) begin
      if (txCnt_q != `CSF_CNT_ZERO) begin
        serialOut <= txShift_q[`CSF_MSB];
        txShift_q <= {txShift_q[`CSF_MSB-1:0], 1'b0};
        txCnt_q <= cntDec(txCnt_q);
      end else begin
        // Release the line one clock after the last bit
        serialOutEnN <= 1'b1;
      end
    end
  end

  // Receive shifter
  reg [`CSF_WORD_BITS-1:0] rxShift_q;
  reg [`CSF_CNT_W-1:0] rxCnt_q;

  always @(posedge ref_clk) begin
    if (rst) begin
      rxShift_q <= `CSF_WORD_ZERO;
      rxCnt_q <= `CSF_CNT_ZERO;
      rxWord <= `CSF_WORD_ZERO;
      rxValid <= 1'b0;
      frameStart <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      frameStart <= fsFall;
      // Falls past the sixteenth meet a zero count and are ignored
      if (fsFall) begin
        rxCnt_q <= `CSF_CNT_RX_LOAD;
      end else if (sclkFall && rxCnt_q != `CSF_CNT_ZERO) begin
        rxShift_q <= {rxShift_q[`CSF_MSB-1:0], dinSync_q};
        rxCnt_q <= cntDec(rxCnt_q);
        if (rxCnt_q == `CSF_CNT_ONE) begin
          rxWord <= {rxShift_q[`CSF_MSB-1:0], dinSync_q};
          rxValid <= 1'b1;
        end
      end
    end
  end

  // Delayed frame sync counter, counted in rising shift clocks
  reg [DELAY_W-1:0] dlyCnt_q;
  reg dlyBusy_q;
  reg dlyLow_q;
  // Delay counter constants at the parameter's width
  localparam [DELAY_W-1:0] DLY_ZERO = {DELAY_W{1'b0}};
  localparam [DELAY_W-1:0] DLY_ONE = {{(DELAY_W-1){1'b0}}, 1'b1};

  always @(posedge ref_clk) begin
    if (rst) begin
      dlyCnt_q <= DLY_ZERO;
      dlyBusy_q <= 1'b0;
      dlyLow_q <= 1'b0;
      delayed_frame_sync_n <= 1'b1;
    end else if (fsFall) begin
      // Same delay input in every chained device gives equal hops
      dlyCnt_q <= fsdDelay;
      dlyLow_q <= 1'b0;
      if (fsdDelay == DLY_ZERO) begin
        delayed_frame_sync_n <= 1'b0;
        dlyLow_q <= 1'b1;
        dlyBusy_q <= 1'b0;
      end else begin
        delayed_frame_sync_n <= 1'b1;
        dlyBusy_q <= 1'b1;
      end
    end else if (sclkRise) begin
      // Low lasts one shift clock, then the next rise lifts it
      if (dlyLow_q) begin
        delayed_frame_sync_n <= 1'b1;
        dlyLow_q <= 1'b0;
      end else if (dlyBusy_q) begin
        if (dlyCnt_q == DLY_ONE) begin
          delayed_frame_sync_n <= 1'b0;
          dlyLow_q <= 1'b1;
          dlyBusy_q <= 1'b0;
        end
        dlyCnt_q <= dlyCnt_q - DLY_ONE;
      end
    end
  end

  // Input range select
  // Gain pins come from logic on this clock, so they need no synchroniser
  wire [1:0] gainCode = {input_gain_sel_hi, input_gain_sel_lo};

  always @(posedge ref_clk) begin
    if (rst) begin
      gainRange <= `CSF_GAIN_RESET;
      squelch <= 1'b1;
      halfScale <= 1'b0;
    end else begin
      gainRange <= gainCode;
      squelch <= (gainCode == `CSF_GAIN_SQUELCH);
      halfScale <= singleEnded && (gainCode == `CSF_GAIN_FULL3V);
    end
  end

endmodule // csf_frame_timing

// ===== testbench/csf_link_model.sv
// Far-side serial port: frame sync, shift clock and input data
`timescale 1ns/1ps
module csf_link_model (
  // Link pins
  output logic shiftClk = 1'b0,
  output logic frame_sync_n = 1'b1,
  output logic serialIn = 1'b0,
  // Frame request
  input wire logic start,
  input wire logic [15:0] linkWord
);
  // Clock runs only inside a frame; data toggles once no bit is carried
  // Spare clocks past the word let a delay of up to 22 clocks rise again
  always @(posedge start) begin
    #3;
    for (int i = 0; i < 24; i++) begin
      shiftClk = 1'b1;
      frame_sync_n = (i != 0);
      serialIn = (i < 16) ? linkWord[15-i] : ~serialIn;
      #40 shiftClk = 1'b0;
      #40;
    end
  end
endmodule // csf_link_model

// ===== testbench/csf_monitor.sv
// Checker on the codec frame timing ports
`timescale 1ns/1ps
module csf_monitor #(parameter DELAY_W = 8) (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Observed ports
  input wire frame_sync_n,
  input wire serialOutEnN,
  input wire delayed_frame_sync_n,
  input wire [DELAY_W-1:0] fsdDelay,
  input wire rxValid,
  input wire frameStart,
  input wire squelch,
  input wire [1:0] gainRange
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence s_low; !delayed_frame_sync_n [*2]; endsequence
  a_squelch_tie: assert property (
    squelch == (gainRange == 2'h0)) else $error("squelch");
  a_fs_start: assert property (
    $fell(frame_sync_n) |-> ##[2:5] frameStart) else $error("fs");
  a_start_drive: assert property (
    frameStart |-> !serialOutEnN) else $error("drive");
  a_word_drive: assert property (
    frameStart |=> !serialOutEnN [*8]) else $error("hold");
  a_en_frame: assert property (
    $fell(serialOutEnN) |-> frameStart) else $error("enable");
  a_rx_pulse: assert property (
    rxValid |=> !rxValid) else $error("rx pulse");
  a_zero_delay: assert property (
    frameStart && fsdDelay == '0 |-> !delayed_frame_sync_n) else $error("zero delay");
  a_fsd_width: assert property (
    $fell(delayed_frame_sync_n) |-> s_low ##[1:12] delayed_frame_sync_n) else $error("fsd");
endmodule // csf_monitor

// ===== testbench/testbench.sv
// Bench for the codec frame timing block
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0, rst = 1'b1, start = 1'b0, singleEnded = 1'b0;
  logic input_gain_sel_hi = 1'b0, input_gain_sel_lo = 1'b0;
  logic [7:0] fsdDelay = 8'h00;
  logic [15:0] txWord = 16'h0000, linkWord = 16'h0000, txSeen = 16'h0000, rxWord;
  logic shiftClk, frame_sync_n, serialIn, serialOut, serialOutEnN, delayed_frame_sync_n;
  logic rxValid, frameStart, squelch, halfScale;
  logic [1:0] gainRange;
  int err_count = 0, n_checks = 0, rxPulses = 0;
  always #5 ref_clk = ~ref_clk;
  // Mid-bit sample, well after the launching rise was acted on
  always @(negedge shiftClk) #20 if (!serialOutEnN) txSeen = {txSeen[14:0], serialOut};
  // One pulse per word, counted mid-cycle where it stands
  always @(negedge ref_clk) if (rxValid === 1'b1) rxPulses++;
  csf_link_model i_csf_link_model (
    .shiftClk(shiftClk),
    .frame_sync_n(frame_sync_n),
    .serialIn(serialIn),
    .start(start),
    .linkWord(linkWord)
  );
  csf_frame_timing i_csf_frame_timing (
    .ref_clk(ref_clk),
    .rst(rst),
    .shiftClk(shiftClk),
    .frame_sync_n(frame_sync_n),
    .serialIn(serialIn),
    .serialOut(serialOut),
    .serialOutEnN(serialOutEnN),
    .delayed_frame_sync_n(delayed_frame_sync_n),
    .fsdDelay(fsdDelay),
    .singleEnded(singleEnded),
    .input_gain_sel_hi(input_gain_sel_hi),
    .input_gain_sel_lo(input_gain_sel_lo),
    .txWord(txWord),
    .rxWord(rxWord),
    .rxValid(rxValid),
    .frameStart(frameStart),
    .squelch(squelch),
    .halfScale(halfScale),
    .gainRange(gainRange)
  );
  task automatic check(input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) err_count++;
    if (seen !== exp) $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic gain_modes();
    for (int i = 0; i < 8; i++) begin
      {singleEnded, input_gain_sel_hi, input_gain_sel_lo} = i[2:0];
      repeat (2) @(negedge ref_clk);
      check({12'h000, gainRange, squelch, halfScale},
        {12'h000, i[1:0], i[1:0] == 2'h0, i == 5});
    end
  endtask
  task automatic frame_xfer(input logic [15:0] tx, rx, input logic [7:0] m);
    int n;
    int p;
    p = rxPulses;
    {fsdDelay, txWord, linkWord, start} = {m, tx, rx, 1'b1};
    for (n = 0; n < 50 && frameStart !== 1'b1; n++) @(negedge ref_clk);
    check({15'h0000, frameStart}, 16'h0001);
    start = 1'b0;
    for (n = 0; n < 300 && delayed_frame_sync_n !== 1'b0; n++) @(negedge ref_clk);
    check(16'(n), 16'(8 * m));
    for (n = 0; n < 300 && serialOutEnN !== 1'b1; n++) @(negedge ref_clk);
    check({15'h0000, serialOutEnN}, 16'h0001);
    // Let the partner's trailing clocks run out before the next frame
    repeat (64) @(negedge ref_clk);
    check(rxWord, rx);
    check(txSeen, tx);
    check(16'(rxPulses - p), 16'h0001);
  endtask
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    gain_modes();
    frame_xfer(16'ha5c3, 16'h3c5a, 8'h00);
    frame_xfer(16'h8001, 16'hfffe, 8'h01);
    frame_xfer(16'h7ffe, 16'h0001, 8'h13);
    end_sim();
  end
  // Whole run needs well under 1000 cycles
  initial begin
    #20000;
    err_count++;
    end_sim();
  end
endmodule // testbench
bind csf_frame_timing csf_monitor #(.DELAY_W(DELAY_W)) i_csf_monitor (
  .ref_clk(ref_clk),
  .rst(rst),
  .frame_sync_n(frame_sync_n),
  .serialOutEnN(serialOutEnN),
  .delayed_frame_sync_n(delayed_frame_sync_n),
  .fsdDelay(fsdDelay),
  .rxValid(rxValid),
  .frameStart(frameStart),
  .squelch(squelch),
  .gainRange(gainRange)
);
